// file: ums_pkg.sv
// Purpose: shared constants and carriers for the host select and modem pin block
// Assumes: one clock, pins synchronous to it
// Notes: modem status bit positions and modem control bit positions
package ums_pkg;
  localparam int MSR_DCTS = 0;
  localparam int MSR_DDSR = 1;
  localparam int MSR_DDCD = 3;
  localparam int MSR_CTS = 4;
  localparam int MSR_DSR = 5;
  localparam int MSR_DCD = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_OUTA = 2;
  localparam int MCR_OUTB = 3;
  localparam int MCR_LOOP = 4;
  localparam logic [7:0] MSR_RESET = 8'h00;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam int RCLK_RATIO = 16;

  // latched bus selection: register address and three chip selects
  typedef struct packed {
    logic [2:0] addr;
    logic selHighA;
    logic selHighB;
    logic selLowN;
  } ums_sel_t;

  // modem status inputs, levels as on the pins
  typedef struct packed {
    logic ctsN;
    logic dsrN;
    logic dcdN;
  } ums_modem_t;

  // pending interrupt sources from the rest of the uart
  typedef struct packed {
    logic rxError;
    logic rxAvail;
    logic rxTimeout;
    logic thrEmpty;
  } ums_irq_src_t;
endpackage

// file: ums_addr_latch.sv
// Purpose: address strobe latch for register and chip selects
// Assumes: strobe low is transparent, high holds
// Notes: output is combinational through when strobe low
`timescale 1ns/1ps
module ums_addr_latch (
  input wire logic clk,
  input wire logic nrst,
  input wire logic address_latch_strobe,
  input ums_pkg::ums_sel_t selIn,
  output ums_pkg::ums_sel_t selOut
);
  import ums_pkg::*;

  ums_sel_t held_q;

  // capture while the strobe is low so the level at its rising edge is kept
  always_ff @(posedge clk) begin
    if (!nrst) begin
      held_q <= '0;
    end else if (!address_latch_strobe) begin
      held_q <= selIn;
    end
  end

  // transparent while low, held while high
  assign selOut = address_latch_strobe ? held_q : selIn;
endmodule

// file: ums_modem_host.sv
// Purpose: host selection, data bus, interrupt and modem pins of a uart
// Assumes: all pins synchronous to clk; shifters and fifos live elsewhere
// Notes: nrst resets the whole block; master_reset_in resets all of it except the address latch
`timescale 1ns/1ps
module ums_modem_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic master_reset_in,
  input wire logic address_latch_strobe,
  input wire logic [2:0] regAddr,
  input wire logic select_high_a,
  input wire logic select_high_b,
  input wire logic select_low_n,
  input wire logic read_strobe_n,
  input wire logic read_strobe,
  input wire logic write_strobe_n,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] regReadData,
  input ums_pkg::ums_modem_t modemIn,
  input ums_pkg::ums_irq_src_t irqSrc,
  input wire logic fifoMode,
  input wire logic msIntEnable,
  input wire logic autoCtsEnable,
  input wire logic rclkTick,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic transceiver_disable_out,
  output logic intOut,
  output logic txEnable,
  output logic rxSampleTick,
  output logic dtrN,
  output logic user_output_a,
  output logic user_output_b,
  output logic [7:0] modem_control_reg,
  output logic chipSelected
);
  import ums_pkg::*;

  ums_sel_t selNow;
  ums_sel_t sel;
  logic rst;
  logic selected;
  logic rdActive;
  logic wrActive;
  logic msrRead;
  logic [7:0] msr;
  logic [7:0] mcr_q;
  logic [2:0] delta_q;
  logic [2:0] prev_q;
  logic [2:0] change;
  logic msIrq_q;
  logic loopMode;
  logic [7:0] dataOut_q;
  logic dataOe_q;
  logic transceiver_disable_out_q;
  logic int_q;
  logic tx_q;
  logic dtr_q;
  logic outA_q;
  logic outB_q;
  logic tick_q;
  logic rclkPrev_q;
  logic [3:0] rclkCnt_q;

  // elaboration check on the receiver clock ratio
  if (RCLK_RATIO != 16) begin : g_badRatio
    $error("receiver clock ratio must be sixteen");
  end

  // select decode used for chip qualification; the checks decode the pins on their own
  function automatic logic isSelected(input ums_sel_t s);
    return s.selHighA && s.selHighB && !s.selLowN;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // selection and strobes

  assign rst = !nrst || master_reset_in;
  assign selNow = '{addr: regAddr, selHighA: select_high_a, selHighB: select_high_b, selLowN: select_low_n};

  ums_addr_latch u_latch (
    .clk(clk),
    .nrst(nrst),
    .address_latch_strobe(address_latch_strobe),
    .selIn(selNow),
    .selOut(sel)
  );

  assign selected = isSelected(sel);
  assign rdActive = selected && (!read_strobe_n || read_strobe);
  assign wrActive = selected && !write_strobe_n;
  assign loopMode = mcr_q[MCR_LOOP];

  ////////////////////////////////////////////////////////////////////////
  // modem control register, written by the cpu

  always_ff @(posedge clk) begin
    if (rst) begin
      mcr_q <= MCR_RESET;
    end else if (wrActive && sel.addr == REG_MCR) begin
      mcr_q <= dataIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modem status: levels, change flags, read clear

  assign change = prev_q ^ {modemIn.dcdN, modemIn.dsrN, modemIn.ctsN};
  assign msrRead = rdActive && sel.addr == REG_MSR;

  // modem status image; levels shown inverted as active high
  always_comb begin
    msr = MSR_RESET;
    msr[MSR_CTS] = !modemIn.ctsN;
    msr[MSR_DSR] = !modemIn.dsrN;
    msr[MSR_DCD] = !modemIn.dcdN;
    msr[MSR_DCTS] = delta_q[0];
    msr[MSR_DDSR] = delta_q[1];
    msr[MSR_DDCD] = delta_q[2];
  end

  // previous pin levels for change detection
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 3'h7;
    end else begin
      prev_q <= {modemIn.dcdN, modemIn.dsrN, modemIn.ctsN};
    end
  end

  // change flags: a new change wins over the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      delta_q <= 3'h0;
    end else if (msrRead) begin
      delta_q <= change;
    end else begin
      delta_q <= delta_q | change;
    end
  end

  // pending modem interrupt, cleared by the status read
  always_ff @(posedge clk) begin
    if (rst) begin
      msIrq_q <= 1'b0;
    end else if (msIntEnable && ((change[0] && !autoCtsEnable) || |change[2:1])) begin
      msIrq_q <= 1'b1;
    end else if (msrRead || !msIntEnable) begin
      msIrq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host bus outputs

  // read data onto the bus only during reads
  always_ff @(posedge clk) begin
    if (rst) begin
      dataOut_q <= 8'h00;
      dataOe_q <= 1'b0;
      transceiver_disable_out_q <= 1'b0;
    end else begin
      dataOe_q <= rdActive;
      transceiver_disable_out_q <= rdActive;
      if (rdActive) begin
        dataOut_q <= (sel.addr == REG_MSR) ? msr : (sel.addr == REG_MCR) ? mcr_q : regReadData;
      end
    end
  end

  // interrupt output from all pending sources, the receive timeout only in fifo mode
  always_ff @(posedge clk) begin
    if (rst) begin
      int_q <= 1'b0;
    end else begin
      int_q <= irqSrc.rxError || irqSrc.rxAvail || (fifoMode && irqSrc.rxTimeout)
        || irqSrc.thrEmpty || msIrq_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modem outputs and transmitter gate

  always_ff @(posedge clk) begin
    if (rst) begin
      dtr_q <= 1'b1;
      outA_q <= 1'b1;
      outB_q <= 1'b1;
      tx_q <= 1'b0;
    end else begin
      dtr_q <= loopMode || !mcr_q[MCR_DTR];
      outA_q <= loopMode || !mcr_q[MCR_OUTA];
      outB_q <= loopMode || !mcr_q[MCR_OUTB];
      tx_q <= !autoCtsEnable || !modemIn.ctsN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver clock: one sample tick per sixteen rising edges of the external clock

  always_ff @(posedge clk) begin
    if (rst) begin
      rclkPrev_q <= 1'b0;
      rclkCnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      rclkPrev_q <= rclkTick;
      tick_q <= 1'b0;
      if (rclkTick && !rclkPrev_q) begin
        rclkCnt_q <= rclkCnt_q + 4'h1;
        tick_q <= (rclkCnt_q == 4'h7);
      end
    end
  end

  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign transceiver_disable_out = transceiver_disable_out_q;
  assign intOut = int_q;
  assign txEnable = tx_q;
  assign rxSampleTick = tick_q;
  assign dtrN = dtr_q;
  assign user_output_a = outA_q;
  assign user_output_b = outB_q;
  assign modem_control_reg = mcr_q;
  assign chipSelected = selected;
endmodule

// file: ums_modem_model.sv
// Purpose: modem pins and receive clock at the far side
// Assumes: levels move just after the clock edge
// Notes: receive clock stands still unless run is high
`timescale 1ns/1ps
module ums_modem_model (
  input wire logic clk,
  input wire logic run,
  input ums_pkg::ums_modem_t pins,
  output ums_pkg::ums_modem_t modemIn,
  output logic rclkTick = 1'h0
);
  import ums_pkg::*;
  // pins follow the wanted levels; receive clock toggles while running
  always @(posedge clk) begin
    modemIn <= pins;
    if (run) rclkTick <= ~rclkTick;
  end
endmodule

// file: ums_modem_host_assertions.sv
// Purpose: pin checks for the host select and modem block
// Assumes: one clock; nrst and master_reset_in both reset
// Notes: answer timing as in the hand-over walk
`timescale 1ns/1ps
module ums_modem_host_assertions
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic master_reset_in,
  input wire logic address_latch_strobe,
  input wire logic select_high_a,
  input wire logic select_high_b,
  input wire logic select_low_n,
  input wire logic read_strobe_n,
  input wire logic read_strobe,
  input wire logic dataOe,
  input wire logic transceiver_disable_out,
  input wire logic rxSampleTick,
  input wire logic dtrN,
  input wire logic user_output_a,
  input wire logic user_output_b,
  input wire logic [7:0] modem_control_reg,
  input wire logic chipSelected
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || master_reset_in);
  // read request taken at this edge
  sequence s_read;
    chipSelected && (!read_strobe_n || read_strobe);
  endsequence
  a_select_decode: assert property (!address_latch_strobe |->
    chipSelected == (select_high_a && select_high_b && !select_low_n)) else $error("select decode");
  a_select_hold: assert property ($past(nrst) && !$past(master_reset_in) && $past(address_latch_strobe)
    && address_latch_strobe |-> $stable(chipSelected)) else $error("latched select moved");
  a_read_answer: assert property (s_read |=> dataOe && transceiver_disable_out)
    else $error("read not answered");
  a_bus_release: assert property (!(chipSelected && (!read_strobe_n || read_strobe)) |=>
    !dataOe && !transceiver_disable_out) else $error("bus driven without read");
  a_dtr_level: assert property ($stable(modem_control_reg) [*2] |->
    dtrN == !(modem_control_reg[MCR_DTR] && !modem_control_reg[MCR_LOOP])) else $error("dtr level");
  a_user_outs: assert property ($stable(modem_control_reg) [*2] |-> {user_output_a, user_output_b} ==
    ~({modem_control_reg[MCR_OUTA], modem_control_reg[MCR_OUTB]} & {2{~modem_control_reg[MCR_LOOP]}}))
    else $error("user outputs");
  a_master_reset: assert property (disable iff (!nrst) master_reset_in |=> dtrN && user_output_a &&
    user_output_b && !dataOe && modem_control_reg == MCR_RESET) else $error("reset levels");
  a_tick_pulse: assert property (rxSampleTick |=> !rxSampleTick [*8]) else $error("tick too close");
endmodule
bind ums_modem_host ums_modem_host_assertions u_chk (.*);

// file: uart_host_select_modem_pins_tb.sv
// Purpose: bench for host select and modem pins
// Assumes: far-side model moves the modem pins
// Notes: bus cycles by task
`timescale 1ns/1ps
module uart_host_select_modem_pins_tb;
  import ums_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, master_reset_in = 1'h0, address_latch_strobe = 1'h0, run = 1'h0;
  logic select_high_a = 1'h1, select_high_b = 1'h1, select_low_n = 1'h0, write_strobe_n = 1'h1;
  logic read_strobe_n = 1'h1, read_strobe = 1'h0, fifoMode = 1'h0, msIntEnable = 1'h1, autoCtsEnable = 1'h0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] dataIn = 8'h00, regReadData = 8'h5a, dataOut, modem_control_reg, d;
  logic dataOe, transceiver_disable_out, intOut, txEnable, rxSampleTick, dtrN, user_output_a, user_output_b;
  logic chipSelected, rclkTick;
  logic [7:0] mv [3] = '{8'h05, 8'h1d, 8'h0a};
  logic [7:0] sv [3] = '{8'h11, 8'h32, 8'hb8};
  ums_modem_t pins = 3'h7, modemIn;
  ums_irq_src_t irqSrc = 4'h0;
  int err_total = 0, checked = 0, cyc = 0, n = 0, m = 0;
  ums_modem_host u_dut (.*);
  ums_modem_model u_far (.clk(clk), .run(run), .pins(pins), .modemIn(modemIn), .rclkTick(rclkTick));
  // clock, tick count and run ceiling
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rxSampleTick === 1'h1) n <= n + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      final_report();
    end
  end
  // compare and verdict
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // wait k edges, then step past them
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one read; hi picks the active-high strobe
  task automatic rd(input logic [2:0] a, input logic hi, input logic oe);
    @(posedge clk);
    regAddr <= a;
    read_strobe <= hi;
    read_strobe_n <= hi;
    @(posedge clk);
    read_strobe <= 1'h0;
    read_strobe_n <= 1'h1;
    #1 d = dataOut;
    cmp({6'h00, dataOe, transceiver_disable_out}, {6'h00, oe, oe});
  endtask
  // one control write, then let the pins follow
  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    regAddr <= REG_MCR;
    dataIn <= v;
    write_strobe_n <= 1'h0;
    @(posedge clk);
    write_strobe_n <= 1'h1;
    tk(2);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    tk(1);
    cmp({4'h0, intOut, dtrN, user_output_a, user_output_b}, 8'h07);
    foreach (mv[i]) begin
      d = mv[i];
      wr(d);
      cmp(modem_control_reg, d);
      cmp({5'h00, dtrN, user_output_a, user_output_b}, {5'h00, ~({d[0], d[2], d[3]} & {3{~d[4]}})});
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) pins[2 - i] <= 1'h0;
      tk(4);
      cmp({7'h00, intOut}, 8'h01);
      rd(REG_MSR, i[0], 1'h1);
      cmp(d, sv[i]);
      tk(2);
      cmp({7'h00, intOut}, 8'h00);
    end
    @(posedge clk) autoCtsEnable <= 1'h1;
    tk(3);
    cmp({7'h00, txEnable}, 8'h01);
    @(posedge clk) pins.ctsN <= 1'h1;
    tk(4);
    cmp({6'h00, intOut, txEnable}, 8'h00);
    rd(REG_MSR, 1'h0, 1'h1);
    cmp(d, 8'ha1);
    // modem interrupt masked: a data-set-ready change is flagged but raises nothing
    @(posedge clk) msIntEnable <= 1'h0;
    pins.dsrN <= 1'h1;
    tk(4);
    cmp({7'h00, intOut}, 8'h00);
    rd(REG_MSR, 1'h0, 1'h1);
    cmp(d, 8'h82);
    @(posedge clk) msIntEnable <= 1'h1;
    @(posedge clk) irqSrc.rxTimeout <= 1'h1;
    tk(3);
    cmp({7'h00, intOut}, 8'h00);
    @(posedge clk) fifoMode <= 1'h1;
    tk(3);
    cmp({7'h00, intOut}, 8'h01);
    @(posedge clk) master_reset_in <= 1'h1;
    tk(1);
    cmp({intOut, dtrN, user_output_a, user_output_b, modem_control_reg[3:0]}, 8'h70);
    @(posedge clk) irqSrc <= 4'h0;
    master_reset_in <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) {select_high_a, select_high_b, select_low_n} <= 3'h6 ^ (3'h4 >> k);
      rd(3'h0, 1'h1, 1'h0);
    end
    @(posedge clk) {select_high_a, select_high_b, select_low_n} <= 3'h6;
    tk(1);
    @(posedge clk) address_latch_strobe <= 1'h1;
    @(posedge clk) select_low_n <= 1'h1;
    rd(3'h0, 1'h1, 1'h1);
    cmp(d, 8'h5a);
    @(posedge clk) address_latch_strobe <= 1'h0;
    run <= 1'h1;
    tk(40);
    m = n;
    tk(320);
    cmp(8'(n - m), 8'h0a);
    final_report();
  end
endmodule
